/* File: pkg/tpc_pkg.sv */
// Shared constants for the two-phase pulse event counter
package tpc_pkg;

  localparam int unsigned CNT_W         = 16;
  localparam logic [15:0] CNT_RESET     = 16'h0000;
  localparam logic [15:0] RELOAD_RESET  = 16'h0000;
  localparam logic [15:0] CNT_MAX       = 16'hffff;
  localparam logic [15:0] CNT_MIN       = 16'h0000;
  localparam logic [15:0] CNT_ONE       = 16'h0001;
  // Cycles from a pin change to the counter update it causes
  localparam int unsigned PIN_LATENCY   = 3;

  // Instance numbers that fix the processing choice, or leave it selectable for instance three
  localparam int unsigned INST_NORMAL_ONLY = 2;
  localparam int unsigned INST_SELECTABLE  = 3;
  localparam int unsigned INST_MUL4_ONLY   = 4;

  // Processing mode, one-hot
  typedef enum logic [1:0] {
    TPC_MODE_NORMAL = 2'h1,
    TPC_MODE_MUL4   = 2'h2
  } tpc_mode_t;

endpackage

/* File: rtl/tpc_counter.sv */
// Two-phase pulse event counter with reload register
// Summary of operation
// - While running, a software write changes only the reload register, not the count, unless it lands on a reloading wrap.
// - A value written while running reaches the counter at the next reload.
// - Normal: phase pin high, count-pin rise counts up, fall counts down.
// - Times four: count pin rising with phase high means count up on all edges.
// - Times four: count pin falling with phase high means count down on all edges.
// - Free-running: no reload on overflow or underflow, the count wraps.
// - Only instance three selects processing; two is normal, four is times four.
// - Overflow or underflow loads the counter from the reload register.
// - A write while stopped loads both reload register and counter.
// - Every overflow or underflow raises the interrupt request.
// - Counting runs while the start flag is one and halts when zero.
`timescale 1ns/100ps
module tpc_counter #(
  parameter int unsigned INSTANCE = tpc_pkg::INST_SELECTABLE, // 2, 3 or 4
  parameter int unsigned WIDTH    = tpc_pkg::CNT_W            // Counter width
) (
  input  wire logic             clk_i,                 // Core clock, 250 MHz
  input  wire logic             rst_i,                 // Synchronous reset, active high
  input  wire logic             count_start_i,         // Count start flag
  input  wire logic             free_run_i,            // Free-running option
  input  wire logic             mul4_sel_i,            // Times-four select, instance three only
  input  wire logic             wr_en_i,               // Software write strobe
  input  wire logic [WIDTH-1:0] wr_data_i,             // Software write value
  input  wire logic             count_input_pin_i,     // Count input pin
  input  wire logic             phase_reference_pin_i, // Phase reference pin
  output logic      [WIDTH-1:0] count_o,               // Live count value
  output logic      [WIDTH-1:0] reload_o,              // Reload register value
  output logic                  irq_o,                 // Overflow or underflow, one-cycle pulse
  output logic                  mul4_o                 // Times-four processing in effect
);

  localparam logic [WIDTH-1:0] MAX_V = {WIDTH{1'b1}};
  localparam logic [WIDTH-1:0] MIN_V = {WIDTH{1'b0}};
  localparam logic [WIDTH-1:0] ONE_V = {{(WIDTH-1){1'b0}}, 1'b1};

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic [WIDTH-1:0] reload_r;
  logic             irq_r;
  tpc_pkg::tpc_mode_t mode_w;

  // Pin synchronisers, index 0 count pin, index 1 phase pin
  logic [1:0] pin_raw;
  logic [1:0] lvl_w;
  logic [1:0] prv_w;
  logic [1:0] rise_w;
  logic [1:0] fall_w;

  assign pin_raw = {phase_reference_pin_i, count_input_pin_i};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      tpc_pin_sync u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (pin_raw[gi]),
        .level_o (lvl_w[gi]),
        .prev_o  (prv_w[gi]),
        .rise_o  (rise_w[gi]),
        .fall_o  (fall_w[gi])
      );
    end
  endgenerate

  // Processing choice fixed by instance, except instance three, where mul4_sel_i selects it
  always_comb begin
    mode_w = tpc_pkg::TPC_MODE_NORMAL;
    if (INSTANCE == tpc_pkg::INST_MUL4_ONLY) begin
      mode_w = tpc_pkg::TPC_MODE_MUL4;
    end else if (INSTANCE == tpc_pkg::INST_SELECTABLE && mul4_sel_i) begin
      mode_w = tpc_pkg::TPC_MODE_MUL4;
    end
  end

  assign mul4_o = (mode_w == tpc_pkg::TPC_MODE_MUL4);

  // Step decode
  logic cin_chg;
  logic ph_chg;
  logic step_up;
  logic step_dn;

  assign cin_chg = rise_w[0] | fall_w[0];
  assign ph_chg  = rise_w[1] | fall_w[1];

  always_comb begin
    step_up = 1'b0;
    step_dn = 1'b0;
    case (mode_w)
      tpc_pkg::TPC_MODE_NORMAL: begin
        step_up = lvl_w[1] & rise_w[0];
        step_dn = lvl_w[1] & fall_w[0];
      end
      tpc_pkg::TPC_MODE_MUL4: begin
        // Simultaneous change on both pins is ambiguous and dropped
        if (cin_chg ^ ph_chg) begin
          step_up = lvl_w[1] ^ prv_w[0];
          step_dn = ~(lvl_w[1] ^ prv_w[0]);
        end
      end
      default: begin
        step_up = 1'b0;
        step_dn = 1'b0;
      end
    endcase
  end

  logic run_w;
  logic ovf_w;
  logic unf_w;
  logic wrap_w;

  assign run_w  = count_start_i;
  assign ovf_w  = run_w & step_up & (count_r == MAX_V);
  assign unf_w  = run_w & step_dn & (count_r == MIN_V);
  assign wrap_w = ovf_w | unf_w;

  // Reload register; a running write goes here, and into the count only on a reloading wrap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reload_r <= WIDTH'(tpc_pkg::RELOAD_RESET);
    end else if (wr_en_i) begin
      reload_r <= wr_data_i;
    end
  end

  // A write landing on the reload cycle is taken as the reload value
  always_comb begin
    count_nxt = count_r;
    if (!run_w) begin
      if (wr_en_i) begin
        count_nxt = wr_data_i;
      end
    end else if (wrap_w && !free_run_i) begin
      count_nxt = wr_en_i ? wr_data_i : reload_r;
    end else if (step_up) begin
      count_nxt = count_r + ONE_V;
    end else if (step_dn) begin
      count_nxt = count_r - ONE_V;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= WIDTH'(tpc_pkg::CNT_RESET);
    end else begin
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= wrap_w;
    end
  end

  assign count_o  = count_r;
  assign reload_o = reload_r;
  assign irq_o    = irq_r;

  // Checks

  sequence cin_rise_held_s;
    !count_input_pin_i ##1 count_input_pin_i [*3];
  endsequence

  property run_write_p;
    @(posedge clk_i) disable iff (rst_i)
      (run_w && wr_en_i && !step_up && !step_dn) |=> count_r == $past(count_r);
  endproperty
  run_write_a: assert property (run_write_p)
    else $error("running write disturbed the count");

  // Count takes a running write only when it lands on a reloading wrap
  run_reload_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (run_w && wr_en_i) |=> (reload_r == $past(wr_data_i)) &&
        (count_r == $past(wr_data_i) || !$past(wrap_w) || $past(free_run_i)))
    else $error("running write not held for reload");

  normal_up_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (!mul4_o && run_w && lvl_w[1] && rise_w[0] && count_r != MAX_V)
        |=> count_r == $past(count_r) + ONE_V)
    else $error("normal rising edge did not count up");

  normal_dn_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (!mul4_o && run_w && lvl_w[1] && fall_w[0] && count_r != MIN_V)
        |=> count_r == $past(count_r) - ONE_V)
    else $error("normal falling edge did not count down");

  normal_idle_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (!mul4_o && run_w && !lvl_w[1] && !wr_en_i) |=> $stable(count_r))
    else $error("normal mode counted with phase low");

  mul4_up_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (mul4_o && run_w && prv_w[1] && lvl_w[1] && rise_w[0] && count_r != MAX_V)
        |=> count_r == $past(count_r) + ONE_V)
    else $error("times four did not count up");

  mul4_dn_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (mul4_o && run_w && prv_w[1] && lvl_w[1] && fall_w[0] && count_r != MIN_V)
        |=> count_r == $past(count_r) - ONE_V)
    else $error("times four did not count down");

  free_wrap_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (ovf_w && free_run_i) |=> count_r == MIN_V)
    else $error("free-running overflow did not wrap");

  // Judged on the count, since the mode flag itself is fixed by construction
  fixed_mode_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (INSTANCE == tpc_pkg::INST_NORMAL_ONLY && run_w && ph_chg && !cin_chg)
        |=> $stable(count_r))
    else $error("instance two counted a phase edge");

  fixed_mul4_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (INSTANCE == tpc_pkg::INST_MUL4_ONLY && run_w && ph_chg && !cin_chg &&
        count_r != MAX_V && count_r != MIN_V) |=> !$stable(count_r))
    else $error("instance four ignored a phase edge");

  reload_load_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (wrap_w && !free_run_i && !wr_en_i) |=> count_r == $past(reload_r))
    else $error("wrap did not load reload value");

  stop_write_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (!run_w && wr_en_i) |=> (count_r == $past(wr_data_i)) && (reload_r == $past(wr_data_i)))
    else $error("stopped write did not load both");

  wrap_irq_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      wrap_w |=> irq_o ##1 !irq_o || $past(wrap_w))
    else $error("wrap did not raise interrupt");

  stop_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (!run_w && !wr_en_i) |=> $stable(count_r) && !irq_o)
    else $error("count moved while stopped");

  sync_delay_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (cin_rise_held_s and (!mul4_o && run_w && !wr_en_i && lvl_w[1] && prv_w[1]) [*4])
        |-> rise_w[0])
    else $error("pin edge not seen after synchroniser delay");

endmodule

/* File: rtl/tpc_pin_sync.sv */
// Input synchroniser with edge detection for one pulse pin
`timescale 1ns/100ps
module tpc_pin_sync (
  input  wire logic clk_i,   // Core clock
  input  wire logic rst_i,   // Synchronous reset, active high
  input  wire logic pin_i,   // Raw pin level
  output logic      level_o, // Synchronised level
  output logic      prev_o,  // Synchronised level one cycle earlier
  output logic      rise_o,  // Rising edge, one-cycle pulse
  output logic      fall_o   // Falling edge, one-cycle pulse
);

  logic meta_r;
  logic sync_r;
  logic hist_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      hist_r <= 1'b0;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      hist_r <= sync_r;
    end
  end

  assign level_o = sync_r;
  assign prev_o  = hist_r;
  assign rise_o  = sync_r & ~hist_r;
  assign fall_o  = ~sync_r & hist_r;

endmodule

/* File: test/tb.sv */
// Self-checking bench for the two-phase pulse event counter
`timescale 1ns/100ps
module tb;
  logic        clk = 1'b0, rst = 1'b1, start = 1'b0, frun = 1'b0;
  logic        m4sel = 1'b0, wr_en = 1'b0, step = 1'b0, up = 1'b1;
  logic [15:0] wr_data = 16'h0000;
  logic        cpin, ppin;
  logic [15:0] cnt [3];
  logic [15:0] rel [3];
  logic        irq [3];
  logic        m4 [3];
  int          mismatches = 0, checked = 0, irqs = 0, n;

  always #2 clk = ~clk;

  // Same stimulus into instances two, three and four
  for (genvar g = 0; g < 3; g++) begin : g_inst
    tpc_counter #(.INSTANCE(g + 2), .WIDTH(16)) i_tpc_counter (
      .clk_i(clk), .rst_i(rst), .count_start_i(start), .free_run_i(frun),
      .mul4_sel_i(m4sel), .wr_en_i(wr_en), .wr_data_i(wr_data),
      .count_input_pin_i(cpin), .phase_reference_pin_i(ppin),
      .count_o(cnt[g]), .reload_o(rel[g]), .irq_o(irq[g]), .mul4_o(m4[g]));
  end

  tpc_pulse_src i_tpc_pulse_src (
    .clk_i(clk), .rst_i(rst), .step_i(step), .up_i(up), .mul4_i(m4sel),
    .count_input_pin_o(cpin), .phase_reference_pin_o(ppin));

  always @(posedge clk) if (irq[1] === 1'b1) irqs++;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] d);
    @(posedge clk); #1 wr_en = 1'b1; wr_data = d;
    @(posedge clk); #1 wr_en = 1'b0;
  endtask

  // Pin levels held well beyond two clocks, then the pipeline settles
  task automatic stp(input logic dir);
    @(posedge clk); #1 step = 1'b1; up = dir;
    @(posedge clk); #1 step = 1'b0;
    repeat (5) @(posedge clk);
    #1;
  endtask

  task automatic t_stopped;
    wr(16'h1234);
    chk(cnt[1], 16'h1234);
    chk(rel[1], 16'h1234);
    $display("test stopped write done");
  endtask

  task automatic t_normal;
    wr(16'h0005);
    start = 1'b1;
    stp(1'b1);
    chk(cnt[1], 16'h0006);
    stp(1'b1);
    chk(cnt[1], 16'h0005);
    start = 1'b0;
    stp(1'b1);
    chk(cnt[1], 16'h0005);
    chk(16'(m4[1]), 16'h0000);
    $display("test normal done");
  endtask

  task automatic t_mul4;
    @(posedge clk); #1 m4sel = 1'b1;
    repeat (4) @(posedge clk);
    wr(16'h0010);
    start = 1'b1;
    repeat (4) stp(1'b1);
    chk(cnt[1], 16'h0014);
    chk(cnt[2], 16'h0014);
    chk(cnt[0], 16'h0011);
    stp(1'b0);
    stp(1'b0);
    chk(cnt[1], 16'h0012);
    chk(cnt[0], 16'h0011);
    chk(16'(m4[0]), 16'h0000);
    chk(16'(m4[1]), 16'h0001);
    chk(16'(m4[2]), 16'h0001);
    start = 1'b0;
    $display("test times four done");
  endtask

  task automatic t_reload;
    wr(16'hfffe);
    start = 1'b1;
    wr(16'h0100);
    chk(cnt[1], 16'hfffe);
    chk(rel[1], 16'h0100);
    n = irqs;
    stp(1'b1);
    chk(cnt[1], 16'hffff);
    stp(1'b1);
    chk(cnt[1], 16'h0100);
    chk(16'(irqs - n), 16'h0001);
    start = 1'b0;
    $display("test reload done");
  endtask

  task automatic t_free;
    frun = 1'b1;
    wr(16'h0000);
    start = 1'b1;
    n = irqs;
    stp(1'b0);
    chk(cnt[1], 16'hffff);
    chk(rel[1], 16'h0000);
    stp(1'b1);
    chk(cnt[1], 16'h0000);
    chk(16'(irqs - n), 16'h0002);
    start = 1'b0;
    frun = 1'b0;
    $display("test free run done");
  endtask

  task automatic finish_test;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    t_stopped();
    t_normal();
    t_mul4();
    t_reload();
    t_free();
    finish_test();
  end

  // Whole run needs well under a microsecond of steps
  initial begin
    #20000;
    mismatches++;
    finish_test();
  end
endmodule

/* File: test/tpc_pulse_src.sv */
// Two-phase pulse source model driving the count and phase pins
`timescale 1ns/100ps
module tpc_pulse_src (
  input  wire logic clk_i,                 // Core clock
  input  wire logic rst_i,                 // Reset, active high
  input  wire logic step_i,                // One step per pulse
  input  wire logic up_i,                  // Step direction in times-four
  input  wire logic mul4_i,                // Quadrature pattern when high
  output logic      count_input_pin_o,     // Count input pin
  output logic      phase_reference_pin_o  // Phase reference pin
);
  logic [1:0] pos_r;
  logic       tog_r;
  // Gray order so only one pin moves per step, as a real encoder does
  always_ff @(posedge clk_i) begin
    if (rst_i) pos_r <= 2'h0;
    else if (step_i && mul4_i) pos_r <= up_i ? pos_r + 2'h1 : pos_r - 2'h1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) tog_r <= 1'b0;
    else if (step_i && !mul4_i) tog_r <= ~tog_r;
  end
  assign count_input_pin_o     = mul4_i ? pos_r[1] : tog_r;
  assign phase_reference_pin_o = mul4_i ? ^pos_r : 1'b1;
endmodule
